// File: rtl/ies_sequencer.sv
// Operation
// - Ordinary instruction: resolve at completion, enter sequence the next cycle.
// - String or multiply-accumulate instruction: suspend partway and enter at once.
// - First step reads the reserved address for number and priority level; software entries raise no info_rd and take the number from sw_num.
// - After the read, clear the accepted source's pending bit to 0.
// - Save the flag word from before the sequence into a holding register.
// - Clear the interrupt-enable flag.
// - Clear the single-step flag.
// - Clear the stack-select flag so the interrupt stack is used.
// - Software interrupt 32 to 63 leaves the stack-select flag unchanged.
// - Push the held flag word onto the stack.
// - Then push the program counter; the code pushes only its low 16 bits.
// - Then load the current priority level with the accepted level.
// - Finally load the program counter from the vector and resume fetching.
module ies_sequencer (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_pending,
    input wire logic instr_done,
    input wire logic string_instr,
    input wire logic sw_entry,
    input wire logic [ies_pkg::NUM_W-1:0] sw_num,
    input wire logic [ies_pkg::DATA_W-1:0] info_data,
    input wire logic [ies_pkg::ADDR_W-1:0] vector_addr,
    input wire logic [ies_pkg::DATA_W-1:0] flag_in,
    input wire logic [ies_pkg::ADDR_W-1:0] pc_in,
    input wire logic [ies_pkg::ADDR_W-1:0] sp_in,
    output logic info_rd,
    output logic [ies_pkg::ADDR_W-1:0] info_addr,
    output logic clear_pending,
    output logic [ies_pkg::NUM_W-1:0] clear_num,
    output logic suspend_instr,
    output logic flag_we,
    output logic [ies_pkg::DATA_W-1:0] flag_out,
    output ies_pkg::ies_push_type push,
    output logic [ies_pkg::ADDR_W-1:0] sp_out,
    output logic ipl_we,
    output logic [ies_pkg::IPL_W-1:0] current_priority_level,
    output logic pc_we,
    output logic [ies_pkg::ADDR_W-1:0] pc_out,
    output logic seq_busy
);
    // --------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_n;
    assign rst_n = rst_sync_reg;

    // --------------------------------------------------------------
    // State and holding registers
    // --------------------------------------------------------------
    ies_pkg::ies_state_type state_reg;
    ies_pkg::ies_state_type state_next;
    ies_pkg::ies_info_type info_reg;
    logic [ies_pkg::DATA_W-1:0] hold_flag_reg;
    logic [ies_pkg::ADDR_W-1:0] hold_pc_reg;
    logic [ies_pkg::ADDR_W-1:0] sp_reg;
    logic sw_reg;
    logic [ies_pkg::NUM_W-1:0] sw_num_reg;

    wire logic take_now;
    wire logic suspend_w;
    wire logic busy_w;
    wire logic [ies_pkg::DATA_W-1:0] new_flag;
    wire logic entry;
    wire logic [ies_pkg::ADDR_W-1:0] sp_dec;
    wire ies_pkg::ies_info_type info_w;

    assign busy_w = (state_reg != ies_pkg::IES_IDLE);
    assign entry = take_now | (sw_entry & ~busy_w);
    assign sp_dec = sp_reg - ies_pkg::PUSH_STEP;
    assign info_w = ies_pkg::ies_info_type'(info_data[ies_pkg::NUM_W+ies_pkg::IPL_W-1:0]);

    ies_accept u_accept (
        .req_pending(req_pending),
        .instr_done(instr_done),
        .string_instr(string_instr),
        .seq_busy(busy_w),
        .take_now(take_now),
        .suspend(suspend_w)
    );

    ies_flags u_flags (
        .flag_in(hold_flag_reg),
        .sw_entry(sw_reg),
        .sw_num(sw_num_reg),
        .flag_out(new_flag)
    );

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ies_pkg::IES_IDLE: begin
                if (entry) begin
                    state_next = ies_pkg::IES_INFO;
                end
            end
            ies_pkg::IES_INFO: state_next = ies_pkg::IES_FLAGS;
            ies_pkg::IES_FLAGS: state_next = ies_pkg::IES_PUSH_FLG;
            ies_pkg::IES_PUSH_FLG: state_next = ies_pkg::IES_PUSH_PC;
            ies_pkg::IES_PUSH_PC: state_next = ies_pkg::IES_IPL;
            ies_pkg::IES_IPL: state_next = ies_pkg::IES_VEC;
            ies_pkg::IES_VEC: state_next = ies_pkg::IES_IDLE;
            default: state_next = ies_pkg::IES_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ies_pkg::IES_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Flag word and PC are captured as they stood before any change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_flag_reg <= ies_pkg::FLAG_RESET;
            hold_pc_reg <= ies_pkg::PC_RESET;
            sw_reg <= 1'b0;
            sw_num_reg <= '0;
        end else if (state_reg == ies_pkg::IES_IDLE && entry) begin
            hold_flag_reg <= flag_in;
            hold_pc_reg <= pc_in;
            sw_reg <= sw_entry & ~take_now;
            sw_num_reg <= sw_num;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            info_reg <= '0;
        end else if (state_reg == ies_pkg::IES_INFO) begin
            info_reg <= sw_reg ?
                ies_pkg::ies_info_type'{num: sw_num_reg, level: info_w.level} : info_w;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= ies_pkg::SP_RESET;
        end else if (state_reg == ies_pkg::IES_IDLE && entry) begin
            sp_reg <= sp_in;
        end else if (state_reg == ies_pkg::IES_PUSH_FLG || state_reg == ies_pkg::IES_PUSH_PC) begin
            sp_reg <= sp_dec;
        end
    end

    // --------------------------------------------------------------
    // Registered outputs
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            info_rd <= 1'b0;
            info_addr <= ies_pkg::INFO_ADDR;
            suspend_instr <= 1'b0;
            seq_busy <= 1'b0;
        end else begin
            info_rd <= (state_next == ies_pkg::IES_INFO) && !(sw_entry & ~take_now);
            info_addr <= ies_pkg::INFO_ADDR;
            suspend_instr <= (state_reg == ies_pkg::IES_IDLE) && suspend_w;
            seq_busy <= (state_next != ies_pkg::IES_IDLE);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clear_pending <= 1'b0;
            clear_num <= '0;
        end else begin
            clear_pending <= (state_reg == ies_pkg::IES_INFO) && !sw_reg;
            clear_num <= info_w.num;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_we <= 1'b0;
            flag_out <= ies_pkg::FLAG_RESET;
        end else begin
            flag_we <= (state_reg == ies_pkg::IES_FLAGS);
            flag_out <= new_flag;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            push <= '0;
            sp_out <= ies_pkg::SP_RESET;
        end else begin
            push.valid <= (state_reg == ies_pkg::IES_PUSH_FLG) ||
                (state_reg == ies_pkg::IES_PUSH_PC);
            push.addr <= sp_dec;
            push.data <= (state_reg == ies_pkg::IES_PUSH_FLG) ? hold_flag_reg :
                hold_pc_reg[ies_pkg::DATA_W-1:0];
            sp_out <= sp_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ipl_we <= 1'b0;
            current_priority_level <= ies_pkg::IPL_RESET;
            pc_we <= 1'b0;
            pc_out <= ies_pkg::PC_RESET;
        end else begin
            ipl_we <= (state_reg == ies_pkg::IES_IPL);
            if (state_reg == ies_pkg::IES_IPL) begin
                current_priority_level <= info_reg.level;
            end
            pc_we <= (state_reg == ies_pkg::IES_VEC);
            if (state_reg == ies_pkg::IES_VEC) begin
                pc_out <= vector_addr;
            end
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_boundary_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ies_pkg::IES_IDLE && req_pending && instr_done)
            |=> state_reg == ies_pkg::IES_INFO;
    endproperty
    a_boundary_entry: assert property (p_boundary_entry) else $error("no entry after boundary");

    property p_suspend;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ies_pkg::IES_IDLE && req_pending && string_instr && !instr_done)
            |=> suspend_instr && state_reg == ies_pkg::IES_INFO;
    endproperty
    a_suspend: assert property (p_suspend) else $error("string instr not suspended");

    property p_info_read;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(info_rd) |-> info_addr == ies_pkg::INFO_ADDR && state_reg == ies_pkg::IES_INFO;
    endproperty
    a_info_read: assert property (p_info_read) else $error("info read misplaced");

    property p_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        info_rd |=> clear_pending;
    endproperty
    a_clear: assert property (p_clear) else $error("pending not cleared");

    property p_flags;
        @(posedge sys_clk) disable iff (!rst_n)
        flag_we |-> !flag_out[ies_pkg::FLAG_I_POS] && !flag_out[ies_pkg::FLAG_D_POS]
            ##1 push.valid && push.data == $past(hold_flag_reg);
    endproperty
    a_flags: assert property (p_flags) else $error("flag update or push wrong");

    property p_u_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        (flag_we && !sw_reg) |-> !flag_out[ies_pkg::FLAG_U_POS];
    endproperty
    a_u_flag: assert property (p_u_flag) else $error("stack select not cleared");

    property p_pc_push;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ies_pkg::IES_PUSH_PC) |=>
            push.valid && push.data == hold_pc_reg[ies_pkg::DATA_W-1:0];
    endproperty
    a_pc_push: assert property (p_pc_push) else $error("pc not pushed");

    property p_order;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(seq_busy) |-> ##2 flag_we ##1 push.valid [*2] ##1 ipl_we ##1 pc_we;
    endproperty
    a_order: assert property (p_order) else $error("sequence order broken");

    property p_no_reentry;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_reg != ies_pkg::IES_IDLE) |=> !$rose(info_rd) || state_reg == ies_pkg::IES_INFO;
    endproperty
    a_no_reentry: assert property (p_no_reentry) else $error("re-entry while busy");

    c_boundary: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(info_rd));
    c_suspend: cover property (@(posedge sys_clk) disable iff (!rst_n) suspend_instr);
    c_sw_keep_u: cover property (@(posedge sys_clk) disable iff (!rst_n)
        flag_we && sw_reg && flag_out[ies_pkg::FLAG_U_POS]);
    c_done: cover property (@(posedge sys_clk) disable iff (!rst_n) pc_we);
endmodule

// File: rtl/ies_pkg.sv
package ies_pkg;
    // --------------------------------------------------------------
    // Widths and constants
    // --------------------------------------------------------------
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_W = 6;
    localparam int unsigned IPL_W = 3;
    localparam logic [ADDR_W-1:0] INFO_ADDR = 20'h00000;
    localparam logic [NUM_W-1:0] SW_NUM_LO = 6'h20;
    localparam logic [NUM_W-1:0] SW_NUM_HI = 6'h3f;
    // Flag word bit positions
    localparam int unsigned FLAG_D_POS = 2;
    localparam int unsigned FLAG_U_POS = 7;
    localparam int unsigned FLAG_I_POS = 6;
    localparam logic [DATA_W-1:0] FLAG_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] SP_RESET = 20'h00000;
    localparam logic [ADDR_W-1:0] PC_RESET = 20'h00000;
    localparam logic [IPL_W-1:0] IPL_RESET = 3'h0;
    localparam logic [ADDR_W-1:0] PUSH_STEP = 20'h00002;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        IES_IDLE, IES_INFO, IES_FLAGS, IES_PUSH_FLG, IES_PUSH_PC, IES_IPL, IES_VEC
    } ies_state_type;

    typedef struct packed {
        logic [NUM_W-1:0] num;
        logic [IPL_W-1:0] level;
    } ies_info_type;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ies_push_type;
endpackage

// File: rtl/ies_accept.sv
// ------------------------------------------------------------------
// Decides when a pending request may enter the sequence
// ------------------------------------------------------------------
module ies_accept (
    input wire logic req_pending,
    input wire logic instr_done,
    input wire logic string_instr,
    input wire logic seq_busy,
    output logic take_now,
    output logic suspend
);
    wire logic at_boundary;
    wire logic mid_string;
    assign at_boundary = req_pending & instr_done & ~seq_busy;
    // String and multiply-accumulate work breaks off partway
    assign mid_string = req_pending & string_instr & ~instr_done & ~seq_busy;
    assign take_now = at_boundary | mid_string;
    assign suspend = mid_string;
endmodule

// File: rtl/ies_flags.sv
// ------------------------------------------------------------------
// Flag word update on entry
// ------------------------------------------------------------------
module ies_flags (
    input wire logic [ies_pkg::DATA_W-1:0] flag_in,
    input wire logic sw_entry,
    input wire logic [ies_pkg::NUM_W-1:0] sw_num,
    output logic [ies_pkg::DATA_W-1:0] flag_out
);
    wire logic keep_u;
    assign keep_u = sw_entry && sw_num >= ies_pkg::SW_NUM_LO && sw_num <= ies_pkg::SW_NUM_HI;
    always_comb begin
        flag_out = flag_in;
        flag_out[ies_pkg::FLAG_I_POS] = 1'b0;
        flag_out[ies_pkg::FLAG_D_POS] = 1'b0;
        if (!keep_u) begin
            flag_out[ies_pkg::FLAG_U_POS] = 1'b0;
        end
        // Software numbers 32..63 keep the stack select as it was
    end
endmodule

// File: verif/ies_irq_model.sv
// ------------------------------------------------------------------
// Request side: pending sources and the interrupt information read
// ------------------------------------------------------------------
module ies_irq_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic raise,
    input wire logic [ies_pkg::NUM_W-1:0] raise_num,
    input wire logic [ies_pkg::IPL_W-1:0] raise_level,
    input wire logic clear_pending,
    input wire logic [ies_pkg::NUM_W-1:0] clear_num,
    output logic req_pending,
    output logic [ies_pkg::DATA_W-1:0] info_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] pend_reg;
    logic [ies_pkg::IPL_W-1:0] level_reg [64];
    logic [ies_pkg::DATA_W-1:0] idle_reg;
    logic [ies_pkg::NUM_W-1:0] top_num;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_reg <= '0;
            idle_reg <= 16'h5a5a;
        end else begin
            // Nothing to report: toggle so a stale read cannot pass
            idle_reg <= ~idle_reg;
            if (clear_pending) begin
                pend_reg[clear_num] <= 1'b0;
            end
            if (raise) begin
                pend_reg[raise_num] <= 1'b1;
                level_reg[raise_num] <= raise_level;
            end
        end
    end
    // Highest pending number wins
    always_comb begin
        top_num = '0;
        for (int i = 0; i < 64; i++) begin
            if (pend_reg[i]) begin
                top_num = i[5:0];
            end
        end
    end
    assign req_pending = |pend_reg;
    assign info_data = req_pending ? {7'h00, top_num, level_reg[top_num]} : idle_reg;
endmodule

// File: verif/tb_interrupt_entry_sequencer.sv
module tb_interrupt_entry_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_done = 1'b0;
    logic string_instr = 1'b0;
    logic sw_entry = 1'b0;
    logic raise = 1'b0;
    logic [5:0] sw_num = 6'h00;
    logic [5:0] raise_num = 6'h00;
    logic [2:0] raise_level = 3'h0;
    logic [15:0] flag_in = 16'hffff;
    logic [19:0] pc_in = 20'h12346;
    logic [19:0] sp_in = 20'h00800;
    logic [19:0] vector_addr = 20'h0f000;
    logic req_pending, info_rd, clear_pending, suspend_instr, flag_we, ipl_we, pc_we, seq_busy;
    logic [15:0] info_data, flag_out;
    logic [19:0] info_addr, sp_out, pc_out;
    logic [5:0] clear_num;
    logic [2:0] current_priority_level;
    ies_pkg::ies_push_type push;
    int fails = 0;
    int checked = 0;
    logic [5:0] sw_nums [4] = '{6'h1f, 6'h20, 6'h3f, 6'h00};

    always #12.5 sys_clk = ~sys_clk;

    ies_irq_model i_irq (.sys_clk(sys_clk), .reset_n(reset_n), .raise(raise),
        .raise_num(raise_num), .raise_level(raise_level), .clear_pending(clear_pending),
        .clear_num(clear_num), .req_pending(req_pending), .info_data(info_data));

    ies_sequencer i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .req_pending(req_pending),
        .instr_done(instr_done), .string_instr(string_instr), .sw_entry(sw_entry),
        .sw_num(sw_num), .info_data(info_data), .vector_addr(vector_addr),
        .flag_in(flag_in), .pc_in(pc_in), .sp_in(sp_in), .info_rd(info_rd),
        .info_addr(info_addr), .clear_pending(clear_pending), .clear_num(clear_num),
        .suspend_instr(suspend_instr), .flag_we(flag_we), .flag_out(flag_out),
        .push(push), .sp_out(sp_out), .ipl_we(ipl_we),
        .current_priority_level(current_priority_level), .pc_we(pc_we),
        .pc_out(pc_out), .seq_busy(seq_busy));

    // --------------------------------------------------------------
    // Checking and closing
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [15:0] exp_flag(input logic [15:0] f, input logic sw,
                                             input logic [5:0] n);
        logic [15:0] r;
        r = f;
        r[ies_pkg::FLAG_I_POS] = 1'b0;
        r[ies_pkg::FLAG_D_POS] = 1'b0;
        if (!(sw && n >= 6'h20 && n <= 6'h3f)) begin
            r[ies_pkg::FLAG_U_POS] = 1'b0;
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // Stimulus and sequence walk
    // --------------------------------------------------------------
    task automatic raise_req(input logic [5:0] n, input logic [2:0] l);
        raise = 1'b1;
        raise_num = n;
        raise_level = l;
        @(negedge sys_clk);
        raise = 1'b0;
    endtask

    // Walks the seven steps one cycle apart, starting at seq_busy
    task automatic run_seq(input logic hw, input logic susp, input logic [5:0] num,
                           input logic [2:0] lvl, input logic [15:0] expf);
        int n;
        n = 0;
        while (seq_busy !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 8) begin
                fails++;
                $display("[FAIL] seq_busy expected 1 seen %b", seq_busy);
                test_done();
            end
        end
        chk("info_rd", {19'h0, hw}, {19'h0, info_rd});
        if (hw) chk("info_addr", ies_pkg::INFO_ADDR, info_addr);
        chk("suspend_instr", {19'h0, susp}, {19'h0, suspend_instr});
        @(negedge sys_clk);
        chk("clear_pending", {19'h0, hw}, {19'h0, clear_pending});
        if (hw) chk("clear_num", {14'h0, num}, {14'h0, clear_num});
        chk("info_rd", 20'h0, {19'h0, info_rd});
        @(negedge sys_clk);
        chk("flag_we", 20'h1, {19'h0, flag_we});
        chk("flag_out", {4'h0, expf}, {4'h0, flag_out});
        @(negedge sys_clk);
        chk("push_valid", 20'h1, {19'h0, push.valid});
        chk("push_addr", sp_in - 20'h2, push.addr);
        chk("push_data", {4'h0, flag_in}, {4'h0, push.data});
        // Stop offering boundaries so the next entry is not chained
        instr_done = 1'b0;
        @(negedge sys_clk);
        chk("push_valid", 20'h1, {19'h0, push.valid});
        chk("push_addr", sp_in - 20'h4, push.addr);
        chk("push_data", {4'h0, pc_in[15:0]}, {4'h0, push.data});
        @(negedge sys_clk);
        chk("ipl_we", 20'h1, {19'h0, ipl_we});
        chk("level", {17'h0, lvl}, {17'h0, current_priority_level});
        chk("sp_out", sp_in - 20'h4, sp_out);
        chk("info_rd", 20'h0, {19'h0, info_rd});
        @(negedge sys_clk);
        chk("pc_we", 20'h1, {19'h0, pc_we});
        chk("pc_out", vector_addr, pc_out);
        chk("seq_busy", 20'h0, {19'h0, seq_busy});
        @(negedge sys_clk);
    endtask

    initial begin
        repeat (10) @(negedge sys_clk);
        chk("seq_busy", 20'h0, {19'h0, seq_busy});
        chk("pc_we", 20'h0, {19'h0, pc_we});
        reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk("seq_busy", 20'h0, {19'h0, seq_busy});
        // Ordinary instruction: nothing until its boundary
        raise_req(6'h05, 3'h3);
        repeat (5) @(negedge sys_clk);
        chk("seq_busy", 20'h0, {19'h0, seq_busy});
        instr_done = 1'b1;
        @(negedge sys_clk);
        instr_done = 1'b0;
        run_seq(1'b1, 1'b0, 6'h05, 3'h3, exp_flag(flag_in, 1'b0, 6'h00));
        chk("req_pending", 20'h0, {19'h0, req_pending});
        // Suspendable instruction, other stack and vector
        flag_in = 16'h00c4;
        pc_in = 20'h3a5c8;
        sp_in = 20'h01f00;
        vector_addr = 20'h8c402;
        string_instr = 1'b1;
        raise_req(6'h09, 3'h7);
        run_seq(1'b1, 1'b1, 6'h09, 3'h7, exp_flag(flag_in, 1'b0, 6'h00));
        string_instr = 1'b0;
        // Software entry around the stack-select boundary
        raise_req(6'h02, 3'h6);
        for (int i = 0; i < 4; i++) begin
            sw_num = sw_nums[i];
            sw_entry = 1'b1;
            @(negedge sys_clk);
            sw_entry = 1'b0;
            run_seq(1'b0, 1'b0, sw_num, 3'h6, exp_flag(flag_in, 1'b1, sw_num));
        end
        // Boundaries offered from entry until the flag word push
        raise_req(6'h28, 3'h4);
        instr_done = 1'b1;
        run_seq(1'b1, 1'b0, 6'h28, 3'h4, exp_flag(flag_in, 1'b0, 6'h00));
        // Software request in the same cycle loses to the hardware boundary
        sw_num = 6'h20;
        sw_entry = 1'b1;
        instr_done = 1'b1;
        @(negedge sys_clk);
        sw_entry = 1'b0;
        instr_done = 1'b0;
        run_seq(1'b1, 1'b0, 6'h02, 3'h6, exp_flag(flag_in, 1'b0, 6'h00));
        test_done();
    end
endmodule
